// *** logic/dma_trigger_source_select.sv ***
// trigger source selection for a three-channel transfer controller
//
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1: code 4 triggers on serial A transmit ready
// R2: alternate serial A replaces it, same behaviour
// R3: code 5 triggers on DAC channel 0 ready
// R4: code 6: conversion done, last of sequence
// R5: software-set converter flags never trigger
// R6: converter flags clear on result register access
// R7: sigma-delta master flag triggers, enable suppresses
// R8: code 7 triggers on timer one compare0
// R9: code 8 triggers on timer two compare0
// R10: code 9 triggers on serial B receive
// R11: code A triggers on serial B transmit
// R12: code B triggers on multiplier ready
// R13: code C triggers on serial C receive
// R14: code D triggers on serial C transmit
// R15: code E chains channel completions in ring
// R16: chained completion flags are never auto-cleared
// R17: code F triggers from external pin
// R18: per-channel selector, sources synchronised first
module dma_trigger_source_select #(
	parameter int NUM_CHANNELS = trigger_select_pkg::NUM_CHANNELS
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// peripheral flags and interrupt enables
	input wire trigger_select_pkg::source_flags_t source_flags,
	input wire trigger_select_pkg::source_enables_t source_enables,
	output trigger_select_pkg::source_clears_t source_clears,
	// channel completion flags and external pin
	input wire logic [NUM_CHANNELS-1:0] channel_done_flag,
	input wire logic external_trigger_pin,
	// transfer engine
	output logic [NUM_CHANNELS-1:0] trigger_request,
	input wire logic [NUM_CHANNELS-1:0] transfer_start,
	input wire logic [NUM_CHANNELS-1:0] adc_result_access,
	input wire logic [NUM_CHANNELS-1:0] sigma_delta_result_access,
	// clears toward converter result flags
	output logic adc_result_clear,
	output logic sigma_delta_result_clear
);
	localparam int FLAG_W = $bits(trigger_select_pkg::source_flags_t);
	localparam int SEL_W = trigger_select_pkg::SEL_WIDTH;

	// ==========================================================
	// synchronisation of every source
	trigger_select_pkg::source_flags_t flags;
	logic [NUM_CHANNELS-1:0] done_sync;
	logic ext_sync;

	trigger_sync #(
		.WIDTH(FLAG_W + NUM_CHANNELS + 1)
	) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in({source_flags, channel_done_flag, external_trigger_pin}),
		.sync_out({flags, done_sync, ext_sync}) // R18
	);

	trigger_select_pkg::source_enables_t ie;
	assign ie = source_enables;

	// ==========================================================
	// registers
	logic [SEL_W-1:0] trigger_source_select [NUM_CHANNELS];
	logic [2:0] variant;
	logic [NUM_CHANNELS-1:0] pending;
	logic [NUM_CHANNELS-1:0] last_start;

	// ==========================================================
	// axi4-lite write path
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic do_write;

	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign do_write = aw_held && w_held && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (do_write) begin
				aw_held <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (do_write) begin
				w_held <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= trigger_select_pkg::RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			if (aw_addr == trigger_select_pkg::ADDR_SELECT
				|| aw_addr == trigger_select_pkg::ADDR_VARIANT
				|| aw_addr == trigger_select_pkg::ADDR_STATUS
				|| aw_addr == trigger_select_pkg::ADDR_DONE) begin
				s_axi_bresp <= trigger_select_pkg::RESP_OKAY;
			end else begin
				s_axi_bresp <= trigger_select_pkg::RESP_SLVERR;
			end
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// one selector per channel, packed side by side in one word
	genvar gc;
	generate
		for (gc = 0; gc < NUM_CHANNELS; gc++) begin : g_sel
			localparam int LSB = gc * trigger_select_pkg::SELECT_FIELD_STRIDE;
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					trigger_source_select[gc] <= trigger_select_pkg::SELECT_RESET[LSB +: SEL_W];
				end else if (do_write && aw_addr == trigger_select_pkg::ADDR_SELECT
					&& w_strb[LSB/8]) begin
					trigger_source_select[gc] <= w_data[LSB +: SEL_W]; // R18
				end
			end
		end
	endgenerate

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			variant <= trigger_select_pkg::VARIANT_RESET;
		end else if (do_write && aw_addr == trigger_select_pkg::ADDR_VARIANT && w_strb[0]) begin
			variant <= w_data[2:0];
		end
	end

	// ==========================================================
	// axi4-lite read path
	logic [31:0] read_word;
	logic [31:0] select_word;

	always_comb begin
		select_word = 32'h00000000;
		for (int c = 0; c < NUM_CHANNELS; c++) begin
			select_word[c*trigger_select_pkg::SELECT_FIELD_STRIDE +: SEL_W] =
				trigger_source_select[c];
		end
	end

	always_comb begin
		read_word = 32'h00000000;
		case (s_axi_araddr)
			trigger_select_pkg::ADDR_SELECT: read_word = select_word;
			trigger_select_pkg::ADDR_VARIANT: read_word[2:0] = variant;
			trigger_select_pkg::ADDR_STATUS: begin
				read_word[NUM_CHANNELS-1:0] = pending;
				read_word[trigger_select_pkg::STATUS_START_LSB +: NUM_CHANNELS] = last_start;
			end
			trigger_select_pkg::ADDR_DONE: read_word[NUM_CHANNELS-1:0] = done_sync;
			default: read_word = 32'h00000000;
		endcase
	end

	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= trigger_select_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= read_word;
			if (s_axi_araddr == trigger_select_pkg::ADDR_SELECT
				|| s_axi_araddr == trigger_select_pkg::ADDR_VARIANT
				|| s_axi_araddr == trigger_select_pkg::ADDR_STATUS
				|| s_axi_araddr == trigger_select_pkg::ADDR_DONE) begin
				s_axi_rresp <= trigger_select_pkg::RESP_OKAY;
			end else begin
				s_axi_rresp <= trigger_select_pkg::RESP_SLVERR;
			end
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ==========================================================
	// source qualification
	logic alt_a;
	logic alt_b;
	logic use_sd;
	logic src_a_tx;
	logic src_dac;
	logic src_conv;
	logic src_t1;
	logic src_t2;
	logic src_b_rx;
	logic src_b_tx;
	logic src_mpy;
	logic src_c_rx;
	logic src_c_tx;

	assign alt_a = variant[trigger_select_pkg::VARIANT_SERIAL_A_ALT];
	assign alt_b = variant[trigger_select_pkg::VARIANT_SERIAL_B_ALT];
	assign use_sd = variant[trigger_select_pkg::VARIANT_SIGMA_DELTA];

	assign src_a_tx = alt_a
		? (flags.serial_a_alt_tx_ready_flag && !ie.serial_a_alt_tx_irq_enable) // R2
		: (flags.serial_a_tx_ready_flag && !ie.serial_a_tx_irq_enable); // R1
	assign src_dac = flags.dac_chan0_ready_flag && !ie.dac_chan0_irq_enable; // R3
	// peripheral reports hw_set only for flags set by a completed conversion,
	// which is the last one of a sequence when sequencing
	assign src_conv = use_sd
		? (flags.sigma_delta_result_flag && flags.sigma_delta_hw_set
			&& !ie.sigma_delta_irq_enable) // R7
		: (flags.adc_result_flag && flags.adc_result_hw_set); // R4 R5
	assign src_t1 = flags.timer_one_compare_flag && !ie.timer_one_compare_irq_enable; // R8
	assign src_t2 = flags.timer_two_compare_flag && !ie.timer_two_compare_irq_enable; // R9
	assign src_b_rx = alt_b
		? (flags.serial_b_alt_rx_flag && !ie.serial_b_alt_rx_irq_enable)
		: (flags.serial_b_rx_flag && !ie.serial_b_rx_irq_enable); // R10
	assign src_b_tx = alt_b
		? (flags.serial_b_alt_tx_flag && !ie.serial_b_alt_tx_irq_enable)
		: (flags.serial_b_tx_flag && !ie.serial_b_tx_irq_enable); // R11
	assign src_mpy = flags.multiplier_ready; // R12
	assign src_c_rx = flags.serial_c_rx_flag && !ie.serial_c_rx_irq_enable; // R13
	assign src_c_tx = flags.serial_c_tx_flag && !ie.serial_c_tx_irq_enable; // R14

	// ==========================================================
	// per-channel trigger mux
	logic [NUM_CHANNELS-1:0] selected;

	generate
		for (gc = 0; gc < NUM_CHANNELS; gc++) begin : g_mux
			// ring: channel n is started by channel n-1, channel 0 by the last
			localparam int PREV = (gc == 0) ? NUM_CHANNELS - 1 : gc - 1;
			always_comb begin
				case (trigger_source_select[gc])
					trigger_select_pkg::SEL_SERIAL_A_TX: selected[gc] = src_a_tx;
					trigger_select_pkg::SEL_DAC_CHAN0: selected[gc] = src_dac;
					trigger_select_pkg::SEL_CONVERTER: selected[gc] = src_conv;
					trigger_select_pkg::SEL_TIMER_ONE: selected[gc] = src_t1;
					trigger_select_pkg::SEL_TIMER_TWO: selected[gc] = src_t2;
					trigger_select_pkg::SEL_SERIAL_B_RX: selected[gc] = src_b_rx;
					trigger_select_pkg::SEL_SERIAL_B_TX: selected[gc] = src_b_tx;
					trigger_select_pkg::SEL_MULTIPLIER: selected[gc] = src_mpy;
					trigger_select_pkg::SEL_SERIAL_C_RX: selected[gc] = src_c_rx;
					trigger_select_pkg::SEL_SERIAL_C_TX: selected[gc] = src_c_tx;
					trigger_select_pkg::SEL_CHAIN: selected[gc] = done_sync[PREV]; // R15
					trigger_select_pkg::SEL_EXTERNAL: selected[gc] = ext_sync; // R17
					default: selected[gc] = 1'b0;
				endcase
			end
		end
	endgenerate

	// level request; the engine masks it once it has started
	assign trigger_request = selected;

	// ==========================================================
	// auto-clear at transfer start
	// clears go out combinationally so the flag drops in the start cycle;
	// chain, multiplier and external sources have no clear
	logic [NUM_CHANNELS-1:0] start_code [16];

	always_comb begin
		for (int k = 0; k < 16; k++) begin
			start_code[k] = '0;
		end
		for (int c = 0; c < NUM_CHANNELS; c++) begin
			start_code[trigger_source_select[c]][c] = transfer_start[c];
		end
	end

	always_comb begin
		source_clears = '0;
		source_clears.serial_a_tx_clear =
			|start_code[trigger_select_pkg::SEL_SERIAL_A_TX] && !alt_a; // R1
		source_clears.serial_a_alt_tx_clear =
			|start_code[trigger_select_pkg::SEL_SERIAL_A_TX] && alt_a; // R2
		source_clears.dac_chan0_clear = |start_code[trigger_select_pkg::SEL_DAC_CHAN0]; // R3
		source_clears.timer_one_compare_clear =
			|start_code[trigger_select_pkg::SEL_TIMER_ONE]; // R8
		source_clears.timer_two_compare_clear =
			|start_code[trigger_select_pkg::SEL_TIMER_TWO]; // R9
		source_clears.serial_b_rx_clear = |start_code[trigger_select_pkg::SEL_SERIAL_B_RX] && !alt_b;
		source_clears.serial_b_alt_rx_clear =
			|start_code[trigger_select_pkg::SEL_SERIAL_B_RX] && alt_b; // R10
		source_clears.serial_b_tx_clear = |start_code[trigger_select_pkg::SEL_SERIAL_B_TX] && !alt_b;
		source_clears.serial_b_alt_tx_clear =
			|start_code[trigger_select_pkg::SEL_SERIAL_B_TX] && alt_b; // R11
		source_clears.serial_c_rx_clear = |start_code[trigger_select_pkg::SEL_SERIAL_C_RX]; // R13
		source_clears.serial_c_tx_clear = |start_code[trigger_select_pkg::SEL_SERIAL_C_TX]; // R14
	end

	// converter flags clear on result access, not on start
	assign adc_result_clear = |adc_result_access && !use_sd; // R6
	assign sigma_delta_result_clear = |sigma_delta_result_access && use_sd; // R7
	// chained completion flags: no clear output exists for them // R16

	// ==========================================================
	// status
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pending <= '0;
			last_start <= '0;
		end else begin
			pending <= selected;
			last_start <= transfer_start;
		end
	end
endmodule
`default_nettype wire

// *** logic/trigger_select_pkg.sv ***
// package: register map, selector codes and carrier structs for the trigger selector
package trigger_select_pkg;
	localparam int NUM_CHANNELS = 3;
	localparam int SEL_WIDTH = 4;

	// selector codes
	localparam logic [3:0] SEL_SERIAL_A_TX = 4'h4;
	localparam logic [3:0] SEL_DAC_CHAN0 = 4'h5;
	localparam logic [3:0] SEL_CONVERTER = 4'h6;
	localparam logic [3:0] SEL_TIMER_ONE = 4'h7;
	localparam logic [3:0] SEL_TIMER_TWO = 4'h8;
	localparam logic [3:0] SEL_SERIAL_B_RX = 4'h9;
	localparam logic [3:0] SEL_SERIAL_B_TX = 4'hA;
	localparam logic [3:0] SEL_MULTIPLIER = 4'hB;
	localparam logic [3:0] SEL_SERIAL_C_RX = 4'hC;
	localparam logic [3:0] SEL_SERIAL_C_TX = 4'hD;
	localparam logic [3:0] SEL_CHAIN = 4'hE;
	localparam logic [3:0] SEL_EXTERNAL = 4'hF;

	// register byte offsets
	localparam logic [7:0] ADDR_SELECT = 8'h00;
	localparam logic [7:0] ADDR_VARIANT = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_DONE = 8'h0C;

	// select register: channel n selector at bits [4n+3:4n]
	localparam int SELECT_FIELD_STRIDE = 4;
	localparam logic [11:0] SELECT_RESET = 12'h000;
	// variant register bits
	localparam int VARIANT_SERIAL_A_ALT = 0;
	localparam int VARIANT_SERIAL_B_ALT = 1;
	localparam int VARIANT_SIGMA_DELTA = 2;
	localparam logic [2:0] VARIANT_RESET = 3'h0;
	// status register: pending triggers [2:0], last transfer start pulses [6:4]
	localparam int STATUS_START_LSB = 4;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// peripheral request flags with hardware-set qualifier for converters
	typedef struct packed {
		logic serial_a_tx_ready_flag;
		logic serial_a_alt_tx_ready_flag;
		logic dac_chan0_ready_flag;
		logic adc_result_flag;
		logic adc_result_hw_set;
		logic sigma_delta_result_flag;
		logic sigma_delta_hw_set;
		logic timer_one_compare_flag;
		logic timer_two_compare_flag;
		logic serial_b_rx_flag;
		logic serial_b_alt_rx_flag;
		logic serial_b_tx_flag;
		logic serial_b_alt_tx_flag;
		logic multiplier_ready;
		logic serial_c_rx_flag;
		logic serial_c_tx_flag;
	} source_flags_t;

	typedef struct packed {
		logic serial_a_tx_irq_enable;
		logic serial_a_alt_tx_irq_enable;
		logic dac_chan0_irq_enable;
		logic sigma_delta_irq_enable;
		logic timer_one_compare_irq_enable;
		logic timer_two_compare_irq_enable;
		logic serial_b_rx_irq_enable;
		logic serial_b_alt_rx_irq_enable;
		logic serial_b_tx_irq_enable;
		logic serial_b_alt_tx_irq_enable;
		logic serial_c_rx_irq_enable;
		logic serial_c_tx_irq_enable;
	} source_enables_t;

	// one-cycle clear strobes back to the peripherals
	typedef struct packed {
		logic serial_a_tx_clear;
		logic serial_a_alt_tx_clear;
		logic dac_chan0_clear;
		logic timer_one_compare_clear;
		logic timer_two_compare_clear;
		logic serial_b_rx_clear;
		logic serial_b_alt_rx_clear;
		logic serial_b_tx_clear;
		logic serial_b_alt_tx_clear;
		logic serial_c_rx_clear;
		logic serial_c_tx_clear;
	} source_clears_t;
endpackage

// *** logic/trigger_sync.sv ***
// two-flop synchroniser bank for asynchronous trigger inputs
`timescale 1ns/1ps
`default_nettype none
module trigger_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// data
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;

	// stage1 feeds only sync_out
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stage1 <= '0;
			sync_out <= '0;
		end else begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end
endmodule
`default_nettype wire

// *** verif/dma_trigger_source_select_tb.sv ***
// self-checking bench for the trigger source selector
`timescale 1ns/1ps
`default_nettype none
module dma_trigger_source_select_tb;
	typedef struct packed {
		logic [3:0] code;
		logic [2:0] variant;
		logic [15:0] flags;
		logic [11:0] enables;
		logic req;
		logic [10:0] clears;
	} row_t;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	trigger_select_pkg::source_flags_t source_flags, set_flags, drop_flags;
	trigger_select_pkg::source_enables_t source_enables;
	trigger_select_pkg::source_clears_t source_clears;
	logic [2:0] channel_done_flag, trigger_request, transfer_start, chain;
	logic [2:0] adc_result_access, sigma_delta_result_access;
	logic external_trigger_pin, adc_result_clear, sigma_delta_result_clear;
	int num_errors = 0;
	int checked = 0;
	int cycles = 0;
	row_t rows[29] = '{
		'{4'h4, 3'h0, 16'h8000, 12'h000, 1'h1, 11'h400}, '{4'h4, 3'h0, 16'h8000, 12'h800, 1'h0, 11'h0},
		'{4'h4, 3'h1, 16'h4000, 12'h000, 1'h1, 11'h200}, '{4'h4, 3'h1, 16'h8000, 12'h000, 1'h0, 11'h0},
		'{4'h4, 3'h1, 16'h4000, 12'h400, 1'h0, 11'h000},
		'{4'h5, 3'h0, 16'h2000, 12'h000, 1'h1, 11'h100}, '{4'h5, 3'h0, 16'h2000, 12'h200, 1'h0, 11'h0},
		'{4'h6, 3'h0, 16'h1800, 12'hFFF, 1'h1, 11'h000}, '{4'h6, 3'h0, 16'h1000, 12'h000, 1'h0, 11'h0},
		'{4'h6, 3'h4, 16'h0600, 12'h000, 1'h1, 11'h000}, '{4'h6, 3'h4, 16'h0400, 12'h000, 1'h0, 11'h0},
		'{4'h6, 3'h4, 16'h0600, 12'h100, 1'h0, 11'h000}, '{4'h6, 3'h4, 16'h1800, 12'h000, 1'h0, 11'h0},
		'{4'h7, 3'h0, 16'h0100, 12'h000, 1'h1, 11'h080}, '{4'h7, 3'h0, 16'hFEFF, 12'h000, 1'h0, 11'h0},
		'{4'h7, 3'h0, 16'h0100, 12'h080, 1'h0, 11'h000},
		'{4'h8, 3'h0, 16'h0080, 12'h000, 1'h1, 11'h040}, '{4'h8, 3'h0, 16'h0080, 12'h040, 1'h0, 11'h0},
		'{4'h9, 3'h0, 16'h0040, 12'h000, 1'h1, 11'h020}, '{4'h9, 3'h2, 16'h0020, 12'h000, 1'h1, 11'h010},
		'{4'h9, 3'h0, 16'h0040, 12'h020, 1'h0, 11'h000},
		'{4'hA, 3'h0, 16'h0010, 12'h000, 1'h1, 11'h008}, '{4'hA, 3'h2, 16'h0008, 12'h000, 1'h1, 11'h004},
		'{4'hA, 3'h2, 16'h0008, 12'h004, 1'h0, 11'h000}, '{4'hB, 3'h0, 16'h0004, 12'hFFF, 1'h1, 11'h0},
		'{4'hC, 3'h0, 16'h0002, 12'h000, 1'h1, 11'h002}, '{4'hC, 3'h0, 16'h0002, 12'h002, 1'h0, 11'h0},
		'{4'hD, 3'h0, 16'h0001, 12'h000, 1'h1, 11'h001}, '{4'h0, 3'h0, 16'hFFFF, 12'h000, 1'h0, 11'h0}
	};
	dma_trigger_source_select dut_u (.*);
	peripheral_model periph_u (
		.aclk, .aresetn, .set_flags, .drop_flags, .source_clears, .adc_result_clear,
		.sigma_delta_result_clear, .source_flags
	);
	// ==========================================
	// tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask
	task automatic final_report;
		$display("errors %0d, checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		forever begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid) begin
				resp = s_axi_bresp;
				s_axi_bready <= 1'h0;
				break;
			end
		end
	endtask
	task automatic axi_read(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		forever begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid) begin
				{rd, resp} = {s_axi_rdata, s_axi_rresp};
				s_axi_rready <= 1'h0;
				break;
			end
		end
	endtask
	// ==========================================
	// clock and watchdog
	initial begin
		aclk = 1'h0;
		forever #5 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			final_report();
		end
	end
	// ==========================================
	// main sequence
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, set_flags, drop_flags, source_enables} = '0;
		{channel_done_flag, transfer_start, adc_result_access, sigma_delta_result_access} = '0;
		external_trigger_pin = 1'h0;
		s_axi_wstrb = 4'hF;
		repeat (12) @(posedge aclk);
		aresetn <= 1'h1;
		foreach (rows[i]) begin
			axi_write(trigger_select_pkg::ADDR_VARIANT, {29'h0, rows[i].variant});
			axi_write(trigger_select_pkg::ADDR_SELECT, {28'h0, rows[i].code});
			source_enables <= rows[i].enables;
			set_flags <= rows[i].flags;
			@(posedge aclk);
			set_flags <= '0;
			repeat (3) @(posedge aclk);
			#1;
			check(trigger_request[0], rows[i].req);
			if (rows[i].req) begin
				@(posedge aclk);
				transfer_start <= 3'h1;
				#1;
				check(source_clears, rows[i].clears);
				@(posedge aclk);
				transfer_start <= 3'h0;
				repeat (3) @(posedge aclk);
				#1;
				check(trigger_request[0], rows[i].clears == 11'h0);
			end
			@(posedge aclk);
			{adc_result_access, sigma_delta_result_access} <= 6'h09;
			#1;
			check({adc_result_clear, sigma_delta_result_clear}, {~rows[i].variant[2], rows[i].variant[2]});
			@(posedge aclk);
			{adc_result_access, sigma_delta_result_access} <= 6'h00;
			{drop_flags, source_enables} <= {16'hFFFF, 12'h000};
			@(posedge aclk);
			drop_flags <= '0;
		end
		// each channel keeps its own selector; external pin on channel 2
		axi_write(trigger_select_pkg::ADDR_VARIANT, 32'h0);
		axi_write(trigger_select_pkg::ADDR_SELECT, 32'h00000F87);
		axi_read(trigger_select_pkg::ADDR_SELECT);
		check(rd, 32'h00000F87);
		set_flags <= 16'h0100;
		external_trigger_pin <= 1'h1;
		@(posedge aclk);
		set_flags <= '0;
		repeat (3) @(posedge aclk);
		#1;
		check(trigger_request, 3'h5);
		axi_read(trigger_select_pkg::ADDR_STATUS);
		check(rd, 32'h00000005);
		@(posedge aclk);
		{drop_flags, external_trigger_pin} <= {16'hFFFF, 1'h0};
		axi_write(trigger_select_pkg::ADDR_SELECT, 32'h00000EEE);
		drop_flags <= '0;
		for (int i = 0; i < 3; i++) begin
			chain = 3'h1 << i;
			channel_done_flag <= chain;
			repeat (3) @(posedge aclk);
			#1;
			check(trigger_request, {chain[1:0], chain[2]});
			@(posedge aclk);
			transfer_start <= {chain[1:0], chain[2]};
			#1;
			check(source_clears, 11'h0);
			@(posedge aclk);
			transfer_start <= 3'h0;
			repeat (3) @(posedge aclk);
			#1;
			check(trigger_request, {chain[1:0], chain[2]});
			axi_read(trigger_select_pkg::ADDR_DONE);
			check(rd, {29'h0, chain});
		end
		// bus answers: unmapped place refused, status write accepted with OKAY
		axi_write(8'h10, 32'hFFFFFFFF);
		check(resp, trigger_select_pkg::RESP_SLVERR);
		axi_read(8'h10);
		check({rd, resp}, {32'h0, trigger_select_pkg::RESP_SLVERR});
		axi_write(trigger_select_pkg::ADDR_STATUS, 32'hFFFFFFFF);
		check(resp, trigger_select_pkg::RESP_OKAY);
		axi_read(trigger_select_pkg::ADDR_SELECT);
		check(rd, 32'h00000EEE);
		// reset in mid-run with a chained completion still raised
		aresetn <= 1'h0;
		repeat (2) @(posedge aclk);
		#1;
		check(trigger_request, 3'h0);
		@(posedge aclk);
		aresetn <= 1'h1;
		axi_read(trigger_select_pkg::ADDR_SELECT);
		check(rd, {20'h0, trigger_select_pkg::SELECT_RESET});
		axi_read(trigger_select_pkg::ADDR_VARIANT);
		check(rd, {29'h0, trigger_select_pkg::VARIANT_RESET});
		final_report();
	end
endmodule
`default_nettype wire

// *** verif/peripheral_model.sv ***
// flag bank standing in for converters, timers, serial units and multiplier
`timescale 1ns/1ps
`default_nettype none
module peripheral_model (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// bench stimulus
	input wire trigger_select_pkg::source_flags_t set_flags,
	input wire trigger_select_pkg::source_flags_t drop_flags,
	// clears from the selector
	input wire trigger_select_pkg::source_clears_t source_clears,
	input wire logic adc_result_clear,
	input wire logic sigma_delta_result_clear,
	// flags toward the selector
	output var trigger_select_pkg::source_flags_t source_flags
);
	logic [15:0] clr;
	// multiplier ready is a level with no clear; converter marks drop with their flags
	assign clr = {source_clears[10:8], {2{adc_result_clear}}, {2{sigma_delta_result_clear}},
		source_clears[7:2], 1'h0, source_clears[1:0]};
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			source_flags <= '0;
		end else begin
			source_flags <= (source_flags & ~clr & ~drop_flags) | set_flags;
		end
	end
endmodule
`default_nettype wire

// *** verif/trigger_select_sva.sv ***
// port checks for the trigger source selector
`timescale 1ns/1ps
`default_nettype none
module trigger_select_sva #(
	parameter int NUM_CHANNELS = 3
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// register bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// trigger side
	input wire trigger_select_pkg::source_flags_t source_flags,
	input wire trigger_select_pkg::source_clears_t source_clears,
	input wire logic [NUM_CHANNELS-1:0] channel_done_flag,
	input wire logic external_trigger_pin,
	input wire logic [NUM_CHANNELS-1:0] trigger_request,
	input wire logic [NUM_CHANNELS-1:0] transfer_start,
	input wire logic [NUM_CHANNELS-1:0] adc_result_access,
	input wire logic [NUM_CHANNELS-1:0] sigma_delta_result_access,
	input wire logic adc_result_clear,
	input wire logic sigma_delta_result_clear
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// ==========================================
	// triggers
	AST_RESET_QUIET: assert property (disable iff (1'h0)
		!aresetn |=> !s_axi_bvalid && !s_axi_rvalid && trigger_request == '0)
		else $error("outputs active after reset");
	// two-flop lag: a request needs a source seen two edges earlier
	AST_NO_SOURCE: assert property (
		$past(source_flags, 2) == '0 && $past(channel_done_flag, 2) == '0
		&& !$past(external_trigger_pin, 2) |-> trigger_request == '0)
		else $error("request with no source");
	AST_CLEAR_NEEDS_START: assert property (
		source_clears != '0 |-> transfer_start != '0)
		else $error("source clear without transfer start");
	AST_ADC_CLEAR_CAUSE: assert property (
		adc_result_clear |-> adc_result_access != '0)
		else $error("converter clear without access");
	AST_SD_CLEAR_CAUSE: assert property (
		sigma_delta_result_clear |-> sigma_delta_result_access != '0)
		else $error("sigma-delta clear without access");
	AST_ACCESS_CLEARS: assert property (
		adc_result_access != '0 && sigma_delta_result_access != '0
		|-> adc_result_clear ^ sigma_delta_result_clear)
		else $error("result access cleared no converter flag");
	// ==========================================
	// register bus
	AST_WRITE_ANSWER: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:2] s_axi_bvalid)
		else $error("write response late");
	AST_B_RELEASE: assert property (
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
		else $error("write response not released");
	AST_READ_ANSWER: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	AST_R_RELEASE: assert property (
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read data not released");
endmodule
bind dma_trigger_source_select trigger_select_sva #(.NUM_CHANNELS(NUM_CHANNELS)) sva_u (.*);
`default_nettype wire
